// >>> verilog/bit_test_params.svh
// Constants for the bit-test-skip-if-clear execution block
`ifndef BIT_TEST_PARAMS_SVH
`define BIT_TEST_PARAMS_SVH

// ----------------------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------------------
`define BT_WORD_W 14
`define BT_OPC_MSB 13
`define BT_OPC_LSB 10
`define BT_OPC_VAL 4'h6
`define BT_BIT_MSB 9
`define BT_BIT_LSB 7
`define BT_REG_MSB 6
`define BT_REG_LSB 0
`define BT_REG_W 7
`define BT_BIT_W 3
`define BT_DATA_W 8

// ----------------------------------------------------------------------------
// Reset values and phase timing
// ----------------------------------------------------------------------------
`define BT_REG_RST 7'h00
`define BT_BIT_RST 3'h0
`define BT_PHASE_LAST 2'h3
`define BT_PHASE_STEP 2'h1
`define BT_PHASE_RST 2'h0

`endif

// >>> verilog/bit_test_pkg.sv
// Types shared by the bit-test-skip-if-clear execution block
package bit_test_pkg;

  // Gray sequence along decode -> test -> skip
  typedef enum logic [1:0] {
    ST_DECODE = 2'h0,
    ST_TEST = 2'h1,
    ST_SKIP = 2'h3
  } exec_state_t;

  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h2,
    PH_Q4 = 2'h3
  } phase_t;

endpackage : bit_test_pkg

// >>> verilog/phase_if.sv
// Quadrature phase enables passed from the phase generator to the executor
`timescale 1ns/100ps
interface phase_if;
  logic [1:0] phase;
  logic q1_en;
  logic q2_en;
  logic q3_en;
  logic q4_en;

  modport src (output phase, output q1_en, output q2_en, output q3_en, output q4_en);
  modport dst (input phase, input q1_en, input q2_en, input q3_en, input q4_en);
endinterface : phase_if

// >>> verilog/phase_gen.sv
// Four-phase instruction cycle generator
`timescale 1ns/100ps
`include "bit_test_params.svh"
module phase_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  phase_if.src ph
);

  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  always_comb begin
    if (phase_reg == `BT_PHASE_LAST) begin
      phase_next = `BT_PHASE_RST;
    end else begin
      phase_next = phase_reg + `BT_PHASE_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= `BT_PHASE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Each enable is high for exactly the one clock of its phase
  assign ph.phase = phase_reg;
  assign ph.q1_en = (phase_reg == bit_test_pkg::PH_Q1);
  assign ph.q2_en = (phase_reg == bit_test_pkg::PH_Q2);
  assign ph.q3_en = (phase_reg == bit_test_pkg::PH_Q3);
  assign ph.q4_en = (phase_reg == bit_test_pkg::PH_Q4);

endmodule : phase_gen

// >>> verilog/bit_test_skip_if_clear_exec.sv
// Execution unit for the bit-test-skip-if-clear instruction
//
// Overview of operation
// - Operands: 7-bit register address, 3-bit bit index
// - Bit one: next instruction runs, no idle cycle
// - Bit zero: discard fetched word, run no-op
// - One word; one cycle, two when skipping
`timescale 1ns/100ps
`include "bit_test_params.svh"
module bit_test_skip_if_clear_exec (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [`BT_WORD_W-1:0] INSTR_I,
  input wire logic INSTR_VALID_I,
  input wire logic [`BT_DATA_W-1:0] RDATA_I,
  output logic [`BT_REG_W-1:0] RADDR_O,
  output logic RD_EN_O,
  output logic DECODE_HIT_O,
  output logic TESTED_BIT_O,
  output logic SKIP_TAKEN_O,
  output logic DISCARD_O,
  output logic NOP_CYCLE_O,
  output logic PC_INC_O,
  output logic STATUS_WE_O,
  output logic BUSY_O,
  output logic [1:0] PHASE_O
);

  // --------------------------------------------------------------------------
  // Cycle timing
  // --------------------------------------------------------------------------
  // Q1 edge takes the word, Q2 edge samples the register byte, Q3 edge
  // raises the skip pulse and the Q4 edge either returns to decode or
  // opens the no-op cycle. The no-op cycle lasts one full Q1..Q4 round,
  // so the program counter still steps once per round and the prefetched
  // word is dropped rather than stalled.
  // Limitation: only this one opcode is executed; other words just let
  // the program counter step.

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic is_bit_test_skip_if_clear(input logic [`BT_WORD_W-1:0] w);
    is_bit_test_skip_if_clear = (w[`BT_OPC_MSB:`BT_OPC_LSB] == `BT_OPC_VAL);
  endfunction : is_bit_test_skip_if_clear

  function automatic logic select_bit(input logic [`BT_DATA_W-1:0] d,
                                      input logic [`BT_BIT_W-1:0] idx);
    select_bit = d[idx];
  endfunction : select_bit

  // --------------------------------------------------------------------------
  // Phase generator
  // --------------------------------------------------------------------------
  phase_if ph ();

  phase_gen u_phase_gen (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .ph(ph.src)
  );

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  bit_test_pkg::exec_state_t state_reg;
  bit_test_pkg::exec_state_t state_next;
  logic [`BT_REG_W-1:0] reg_addr_reg;
  logic [`BT_REG_W-1:0] reg_addr_next;
  logic [`BT_BIT_W-1:0] bit_idx_reg;
  logic [`BT_BIT_W-1:0] bit_idx_next;
  logic tested_reg;
  logic tested_next;
  logic rd_en_reg;
  logic rd_en_next;
  logic hit_reg;
  logic hit_next;
  logic skip_reg;
  logic skip_next;
  logic discard_reg;
  logic discard_next;
  logic nop_reg;
  logic nop_next;
  logic pc_inc_reg;
  logic pc_inc_next;
  logic busy_reg;
  logic busy_next;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic status_we_reg;
  logic status_we_next;
  logic accept_word;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    reg_addr_next = reg_addr_reg;
    bit_idx_next = bit_idx_reg;
    tested_next = tested_reg;
    rd_en_next = 1'b0;
    hit_next = 1'b0;
    skip_next = 1'b0;
    discard_next = 1'b0;
    nop_next = nop_reg;
    // Program counter advances once per instruction cycle, no-op cycle included
    pc_inc_next = ph.q4_en;
    busy_next = busy_reg;
    phase_next = ph.phase;
    status_we_next = 1'b0;
    accept_word = ph.q1_en && INSTR_VALID_I && is_bit_test_skip_if_clear(INSTR_I);

    case (state_reg)
      bit_test_pkg::ST_DECODE: begin
        nop_next = 1'b0;
        busy_next = 1'b0;
        if (accept_word) begin
          reg_addr_next = INSTR_I[`BT_REG_MSB:`BT_REG_LSB];
          bit_idx_next = INSTR_I[`BT_BIT_MSB:`BT_BIT_LSB];
          // Read strobe covers Q2 so data is sampled on the Q2 edge
          rd_en_next = 1'b1;
          hit_next = 1'b1;
          busy_next = 1'b1;
          state_next = bit_test_pkg::ST_TEST;
        end
      end

      bit_test_pkg::ST_TEST: begin
        if (ph.q2_en) begin
          tested_next = select_bit(RDATA_I, bit_idx_reg);
        end
        if (ph.q3_en) begin
          skip_next = ~tested_reg;
        end
        if (ph.q4_en) begin
          if (tested_reg) begin
            // Bit set: next word flows straight into decode
            state_next = bit_test_pkg::ST_DECODE;
            busy_next = 1'b0;
          end else begin
            // Bit clear: the prefetched word is thrown away
            discard_next = 1'b1;
            nop_next = 1'b1;
            state_next = bit_test_pkg::ST_SKIP;
          end
        end
      end

      bit_test_pkg::ST_SKIP: begin
        // Whatever sits on the fetch port this cycle is never decoded
        if (ph.q4_en) begin
          nop_next = 1'b0;
          busy_next = 1'b0;
          state_next = bit_test_pkg::ST_DECODE;
        end
      end

      default: begin
        state_next = bit_test_pkg::ST_DECODE;
        nop_next = 1'b0;
        busy_next = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_reg <= bit_test_pkg::ST_DECODE;
      reg_addr_reg <= `BT_REG_RST;
      bit_idx_reg <= `BT_BIT_RST;
      tested_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      hit_reg <= 1'b0;
      skip_reg <= 1'b0;
      discard_reg <= 1'b0;
      nop_reg <= 1'b0;
      pc_inc_reg <= 1'b0;
      busy_reg <= 1'b0;
      phase_reg <= `BT_PHASE_RST;
      status_we_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      reg_addr_reg <= reg_addr_next;
      bit_idx_reg <= bit_idx_next;
      tested_reg <= tested_next;
      rd_en_reg <= rd_en_next;
      hit_reg <= hit_next;
      skip_reg <= skip_next;
      discard_reg <= discard_next;
      nop_reg <= nop_next;
      pc_inc_reg <= pc_inc_next;
      busy_reg <= busy_next;
      phase_reg <= phase_next;
      status_we_reg <= status_we_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign RADDR_O = reg_addr_reg;
  assign RD_EN_O = rd_en_reg;
  assign DECODE_HIT_O = hit_reg;
  assign TESTED_BIT_O = tested_reg;
  assign SKIP_TAKEN_O = skip_reg;
  assign DISCARD_O = discard_reg;
  assign NOP_CYCLE_O = nop_reg;
  assign PC_INC_O = pc_inc_reg;
  assign BUSY_O = busy_reg;
  assign PHASE_O = phase_reg;

  // Status flags are never written by this instruction
  assign STATUS_WE_O = status_we_reg;

endmodule : bit_test_skip_if_clear_exec

// >>> tb/bit_test_monitor.sv
// Concurrent checks on the executor's ports
`timescale 1ns/100ps
`include "bit_test_params.svh"
module bit_test_monitor (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [`BT_REG_W-1:0] RADDR_O,
  input wire logic RD_EN_O,
  input wire logic DECODE_HIT_O,
  input wire logic TESTED_BIT_O,
  input wire logic SKIP_TAKEN_O,
  input wire logic DISCARD_O,
  input wire logic NOP_CYCLE_O,
  input wire logic PC_INC_O,
  input wire logic STATUS_WE_O,
  input wire logic BUSY_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  chk_hit_read: assert property (DECODE_HIT_O |-> RD_EN_O && BUSY_O)
    else $error("decode hit without read strobe");
  chk_one_per_cycle: assert property (DECODE_HIT_O |=> !DECODE_HIT_O [*3])
    else $error("decode hits closer than one cycle");
  chk_clear_skips: assert property (DECODE_HIT_O ##1 !TESTED_BIT_O |=> SKIP_TAKEN_O)
    else $error("clear bit without skip");
  chk_set_runs: assert property (
    DECODE_HIT_O ##1 TESTED_BIT_O |=> !SKIP_TAKEN_O ##1 (!NOP_CYCLE_O && PC_INC_O))
    else $error("set bit caused skip or idle cycle");
  chk_nop_window: assert property (SKIP_TAKEN_O |=> (DISCARD_O && NOP_CYCLE_O)
    ##1 (!DISCARD_O && NOP_CYCLE_O) [*3] ##1 !NOP_CYCLE_O)
    else $error("inserted no-op cycle has wrong shape");
  chk_flags_kept: assert property (!STATUS_WE_O)
    else $error("status write during execution");
  chk_pc_period: assert property (PC_INC_O |=> !PC_INC_O [*3] ##1 PC_INC_O)
    else $error("program counter step not once per cycle");
  chk_addr_held: assert property ($changed(RADDR_O) |-> DECODE_HIT_O)
    else $error("register address moved without a decode");
  chk_nop_ignores: assert property (NOP_CYCLE_O |-> !DECODE_HIT_O)
    else $error("word decoded inside the no-op cycle");
endmodule : bit_test_monitor
bind bit_test_skip_if_clear_exec bit_test_monitor i_mon (.MCLK_I(MCLK_I), .RST_I(RST_I),
  .RADDR_O(RADDR_O), .RD_EN_O(RD_EN_O), .DECODE_HIT_O(DECODE_HIT_O),
  .TESTED_BIT_O(TESTED_BIT_O), .SKIP_TAKEN_O(SKIP_TAKEN_O), .DISCARD_O(DISCARD_O),
  .NOP_CYCLE_O(NOP_CYCLE_O), .PC_INC_O(PC_INC_O), .STATUS_WE_O(STATUS_WE_O),
  .BUSY_O(BUSY_O));

// >>> tb/reg_file_model.sv
// Data register file answering the executor's reads
`timescale 1ns/100ps
module reg_file_model (
  input wire logic clk_i,
  input wire logic rd_en_i,
  input wire logic [6:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [128];
  logic [7:0] last_reg = 8'h00;
  // Outside the strobe the bus inverts every cycle, so a sample one cycle late sees the byte inverted
  always_ff @(posedge clk_i) last_reg <= rdata_o;
  assign rdata_o = rd_en_i ? mem[raddr_i] : ~last_reg;
endmodule : reg_file_model

// >>> tb/bit_test_skip_if_clear_exec_tb_top.sv
// Self-checking bench for the bit-test-skip-if-clear executor
`timescale 1ns/100ps
module bit_test_skip_if_clear_exec_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] instr = 14'h0000;
  logic vld = 1'b0;
  logic [7:0] rdata;
  logic [6:0] raddr;
  logic [1:0] phase;
  logic rd_en, hit, tbit, skip, disc, nop, pc_inc, st_we, busy;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  always #12.5 mclk = ~mclk;
  bit_test_skip_if_clear_exec i_dut (.MCLK_I(mclk), .RST_I(rst), .INSTR_I(instr),
    .INSTR_VALID_I(vld), .RDATA_I(rdata), .RADDR_O(raddr), .RD_EN_O(rd_en),
    .DECODE_HIT_O(hit), .TESTED_BIT_O(tbit), .SKIP_TAKEN_O(skip), .DISCARD_O(disc),
    .NOP_CYCLE_O(nop), .PC_INC_O(pc_inc), .STATUS_WE_O(st_we), .BUSY_O(busy),
    .PHASE_O(phase));
  reg_file_model i_rf (.clk_i(mclk), .rd_en_i(rd_en), .raddr_i(raddr), .rdata_o(rdata));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic cmp_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_flag
  task automatic cmp_addr(input logic [6:0] got, input logic [6:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_addr
  task automatic cmp_phase(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_phase
  // One instruction cycle, plus the no-op cycle when it skips; the model predicts decode, tested bit and skip
  task automatic exec(input logic [13:0] w, input logic v);
    logic h;
    logic b;
    logic s;
    h = v && w[13:10] == 4'h6;
    b = i_rf.mem[w[6:0]][w[9:7]];
    s = h && !b;
    instr <= w;
    vld <= v;
    @(posedge mclk);
    #1;
    cmp_flag(hit, h);
    cmp_flag(rd_en, h);
    cmp_flag(busy, h);
    cmp_phase(phase, 2'h0);
    if (h) cmp_addr(raddr, w[6:0]);
    @(posedge mclk);
    #1;
    if (h) cmp_flag(tbit, b);
    cmp_phase(phase, 2'h1);
    @(posedge mclk);
    #1;
    cmp_flag(skip, s);
    cmp_flag(st_we, 1'b0);
    cmp_phase(phase, 2'h2);
    @(posedge mclk);
    if (s) begin
      // A decodable word inside the no-op cycle must still be dropped
      instr <= {4'h6, w[9:0]};
      #1;
      cmp_flag(disc, 1'b1);
      cmp_flag(nop, 1'b1);
      cmp_flag(pc_inc, 1'b1);
      cmp_phase(phase, 2'h3);
      @(posedge mclk);
      #1;
      cmp_flag(hit, 1'b0);
      cmp_flag(busy, 1'b1);
      repeat (3) @(posedge mclk);
    end
  endtask : exec
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(59));
    for (int a = 0; a < 128; a++) i_rf.mem[a] = 8'($urandom);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 32; k++) begin
      i_rf.mem[k[3] ? 127 : 0] = k[4] ? 8'h55 : 8'haa;
      exec({4'h6, k[2:0], k[3] ? 7'h7f : 7'h00}, 1'b1);
    end
    $display("test 1 done");
    for (int n = 0; n < 16; n++) begin
      exec({n[3:0], 10'h3ff}, 1'b1);
      exec({4'h6, 10'h000}, 1'b0);
    end
    $display("test 2 done");
    repeat (40) begin
      exec({4'h6, 10'($urandom)}, 1'b1);
      exec(14'($urandom), 1'($urandom));
    end
    $display("test 3 done");
    wrap_up();
  end
endmodule : bit_test_skip_if_clear_exec_tb_top
